/* File: rtl/tsrf_regs.svh */
// constants for the supplemental timing report framer
`ifndef TSRF_REGS_SVH
`define TSRF_REGS_SVH
`define TSRF_SUBCODE 8'hAC
`define TSRF_LEN 7'd68
`define TSRF_LAST 7'd67
`define TSRF_SURVEY_DONE 8'h64
`define TSRF_OFF_MODE 7'd1
`define TSRF_OFF_PROG 7'd3
`define TSRF_OFF_ALARM 7'd10
`define TSRF_OFF_DEC 7'd12
`define TSRF_OFF_BIAS 7'd16
`define TSRF_OFF_RATE 7'd20
`define TSRF_OFF_LAT 7'd36
`define TSRF_OFF_LON 7'd44
`define TSRF_OFF_ALT 7'd52
`define TSRF_OFF_QERR 7'd60
`define TSRF_OFF_PPS 7'd64
`define TSRF_AL_OPEN 1
`define TSRF_AL_SHORT 2
`define TSRF_AL_NOSV 3
`define TSRF_AL_SURVEY 5
`define TSRF_AL_NOPOS 6
`define TSRF_AL_LEAP 7
`define TSRF_AL_TEST 8
`define TSRF_AL_POSBAD 9
`define TSRF_AL_SEG 10
`define TSRF_AL_ALM 11
`define TSRF_SEG_MASK 16'h1FFC
`define TSRF_GAP_NS 1000
`define TSRF_CLK_NS 50
`define TSRF_GAP_CYC ((`TSRF_GAP_NS + `TSRF_CLK_NS - 1) / `TSRF_CLK_NS)
`endif

/* File: rtl/tsrf_pkg.sv */
// types for the supplemental timing report framer
package tsrf_pkg;
  typedef enum logic [2:0] {
    MODE_AUTO = 3'h0, MODE_SINGLE = 3'h1, MODE_2D = 3'h3, MODE_3D = 3'h4,
    MODE_DREF = 3'h5, MODE_HOLD2D = 3'h6, MODE_OVERDET = 3'h7
  } tsrf_mode_e;
  typedef struct packed {
    logic [63:0] lat;
    logic [63:0] lon;
    logic [63:0] alt;
  } tsrf_pos_s;
  typedef struct packed {
    logic ant_open;
    logic ant_short;
    logic no_usable_sv;
    logic survey_active;
    logic no_stored_pos;
    logic leap_pending;
    logic test_mode;
    logic pos_suspect;
    logic almanac_bad;
  } tsrf_alarm_s;
  typedef struct packed {
    logic [7:0] decode_status;
    logic [31:0] bias;
    logic [31:0] bias_rate;
    logic [31:0] qerr;
    logic pps_generated;
  } tsrf_timing_s;
  typedef logic [7:0] tsrf_byte_t;
endpackage

/* File: rtl/tsrf_fifo.sv */
// byte fifo between report assembly and the serial transport
`timescale 1ns/1ps
`default_nettype none
module tsrf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/tsrf_posavg.sv */
// running average of position fixes during a self-survey
`timescale 1ns/1ps
`default_nettype none
module tsrf_posavg (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic fix_valid,
  input wire tsrf_pkg::tsrf_pos_s fix,
  input wire tsrf_pkg::tsrf_pos_s avg_in,
  output tsrf_pkg::tsrf_pos_s avg
);
  // averaging of doubles is done upstream; this holds the latest
  // running average delivered with each surveyed fix, or the fix itself when start is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avg <= '0;
    end else if (start) begin
      avg <= fix;
    end else if (fix_valid) begin
      avg <= avg_in;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/tsrf_framer.sv */
// supplemental timing report framer top level
`timescale 1ns/1ps
`default_nettype none
`include "tsrf_regs.svh"
module tsrf_framer #(
  parameter int FIFO_DEPTH = 16,
  parameter int GAP_CYC = `TSRF_GAP_CYC
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // triggers
  input wire logic OUT_ENABLE_I,
  input wire logic PRIMARY_DONE_I,
  input wire logic POLL_I,
  // configuration and status
  input wire tsrf_pkg::tsrf_mode_e MODE_I,
  input wire logic [7:0] SURVEY_PROGRESS_I,
  input wire logic SURVEY_ACTIVE_I,
  input wire tsrf_pkg::tsrf_alarm_s ALARM_I,
  input wire logic [15:0] SEG_STATUS_I,
  input wire logic SEG_CORRUPT_SET_I,
  input wire logic SEG_QUERY_I,
  input wire tsrf_pkg::tsrf_timing_s TIMING_I,
  // positions
  input wire logic FIX_VALID_I,
  input wire tsrf_pkg::tsrf_pos_s FIX_POS_I,
  input wire tsrf_pkg::tsrf_pos_s SURVEY_AVG_I,
  input wire tsrf_pkg::tsrf_pos_s TIMING_POS_I,
  // byte stream out
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  // status
  output logic BUSY_O,
  output logic SEG_ALARM_O
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEND} tsrf_state_e;
  tsrf_state_e state;
  logic auto_pend;
  logic poll_pend;
  logic [15:0] gap_cnt;
  logic [6:0] idx;
  logic seg_alarm;
  tsrf_pkg::tsrf_pos_s prev_fix;
  tsrf_pkg::tsrf_pos_s last_fix;
  tsrf_pkg::tsrf_pos_s avg_pos;
  tsrf_pkg::tsrf_pos_s snap_pos;
  tsrf_pkg::tsrf_timing_s snap_tim;
  logic [15:0] snap_alarm;
  logic [7:0] snap_mode;
  logic [7:0] snap_prog;
  logic [543:0] frame;
  tsrf_pkg::tsrf_byte_t cur_byte;
  logic fifo_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic push;
  logic start_frame;
  logic survey_run;
  logic time_only;
  logic [15:0] alarm_word;
  tsrf_pkg::tsrf_pos_s next_pos;

  // --- pending requests
  // ============================================================
  // trigger capture
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      auto_pend <= 1'b0;
      poll_pend <= 1'b0;
    end else begin
      if (PRIMARY_DONE_I && OUT_ENABLE_I) begin
        auto_pend <= 1'b1;
      end else if (start_frame && !poll_pend) begin
        auto_pend <= 1'b0;
      end
      if (POLL_I) begin
        poll_pend <= 1'b1;
      end else if (start_frame) begin
        poll_pend <= 1'b0;
      end
    end
  end

  // ============================================================
  // sequencing
  assign start_frame = (state == ST_IDLE) && (poll_pend ||
    (auto_pend && gap_cnt == 16'(GAP_CYC)));
  assign push = (state == ST_SEND) && fifo_ready;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      gap_cnt <= '0;
    end else if (PRIMARY_DONE_I) begin
      gap_cnt <= '0;
    end else if (gap_cnt != 16'(GAP_CYC)) begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= ST_IDLE;
      idx <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          idx <= '0;
          if (start_frame) begin
            state <= ST_SEND;
          end
        end
        ST_WAIT: begin
          state <= ST_IDLE;
        end
        ST_SEND: begin
          if (push) begin
            if (idx == `TSRF_LAST) begin
              state <= ST_WAIT;
            end
            idx <= idx + 7'd1;
          end
        end
      endcase
    end
  end

  // ============================================================
  // position selection
  tsrf_posavg u_avg (
    .clk(CLK_I),
    .rst(SYS_RST_I),
    .start(SURVEY_ACTIVE_I && SURVEY_PROGRESS_I == 8'h00 && FIX_VALID_I),
    .fix_valid(FIX_VALID_I && SURVEY_ACTIVE_I),
    .fix(FIX_POS_I),
    .avg_in(SURVEY_AVG_I),
    .avg(avg_pos)
  );

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      last_fix <= '0;
      prev_fix <= '0;
    end else if (FIX_VALID_I) begin
      last_fix <= FIX_POS_I;
    end else if (PRIMARY_DONE_I) begin
      prev_fix <= last_fix;
    end
  end

  assign survey_run = SURVEY_ACTIVE_I &&
    (SURVEY_PROGRESS_I < `TSRF_SURVEY_DONE);
  assign time_only = (MODE_I == tsrf_pkg::MODE_SINGLE) ||
    (MODE_I == tsrf_pkg::MODE_HOLD2D) ||
    (MODE_I == tsrf_pkg::MODE_OVERDET);

  always_comb begin
    if (survey_run) begin
      next_pos = avg_pos;
    end else if (time_only || SURVEY_ACTIVE_I) begin
      next_pos = TIMING_POS_I;
    end else begin
      next_pos = prev_fix;
    end
  end

  // ============================================================
  // alarms
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      seg_alarm <= 1'b0;
    end else if (SEG_CORRUPT_SET_I &&
                 (SEG_STATUS_I & `TSRF_SEG_MASK) != 16'h0000) begin
      seg_alarm <= 1'b1;
    end else if (SEG_QUERY_I) begin
      seg_alarm <= 1'b0;
    end
  end

  always_comb begin
    alarm_word = 16'h0000;
    alarm_word[`TSRF_AL_OPEN] = ALARM_I.ant_open;
    alarm_word[`TSRF_AL_SHORT] = ALARM_I.ant_short;
    alarm_word[`TSRF_AL_NOSV] = ALARM_I.no_usable_sv;
    alarm_word[`TSRF_AL_SURVEY] = survey_run;
    alarm_word[`TSRF_AL_NOPOS] = ALARM_I.no_stored_pos;
    alarm_word[`TSRF_AL_LEAP] = ALARM_I.leap_pending;
    alarm_word[`TSRF_AL_TEST] = ALARM_I.test_mode;
    alarm_word[`TSRF_AL_POSBAD] = ALARM_I.pos_suspect;
    alarm_word[`TSRF_AL_SEG] = seg_alarm;
    alarm_word[`TSRF_AL_ALM] = ALARM_I.almanac_bad;
  end

  // ============================================================
  // snapshot at frame start so one report is self-consistent
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      snap_pos <= '0;
      snap_tim <= '0;
      snap_alarm <= '0;
      snap_mode <= '0;
      snap_prog <= '0;
    end else if (start_frame) begin
      snap_pos <= next_pos;
      snap_tim <= TIMING_I;
      snap_alarm <= alarm_word;
      snap_mode <= {5'h00, MODE_I};
      snap_prog <= SURVEY_PROGRESS_I;
    end
  end

  // ============================================================
  // frame image, byte 0 in the top bits, fields msb first
  assign frame = {
    `TSRF_SUBCODE, snap_mode, 8'h00, snap_prog,
    48'h0000_0000_0000,
    snap_alarm, snap_tim.decode_status, 24'h00_0000,
    snap_tim.bias, snap_tim.bias_rate,
    96'h0000_0000_0000_0000_0000_0000,
    snap_pos.lat, snap_pos.lon, snap_pos.alt,
    snap_tim.qerr, {7'h00, snap_tim.pps_generated},
    24'h00_0000
  };

  always_comb begin
    cur_byte = frame[543 - 8 * 32'(idx) -: 8];
  end

  // ============================================================
  // output buffer
  tsrf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK_I),
    .rst(SYS_RST_I),
    .in_data(cur_byte),
    .in_valid(state == ST_SEND),
    .in_ready(fifo_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(!TX_VALID_O || TX_READY_I)
  );

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      TX_DATA_O <= 8'h00;
      TX_VALID_O <= 1'b0;
      BUSY_O <= 1'b0;
      SEG_ALARM_O <= 1'b0;
    end else begin
      if (!TX_VALID_O || TX_READY_I) begin
        TX_VALID_O <= fifo_valid;
        TX_DATA_O <= fifo_data;
      end
      BUSY_O <= (state != ST_IDLE) || start_frame;
      SEG_ALARM_O <= seg_alarm;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tsrf_host.sv */
// host model that accepts report bytes and collects whole frames
`timescale 1ns/1ps
`default_nettype none
module tsrf_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte stream
  input wire logic [7:0] data_i,
  input wire logic valid_i,
  output logic ready_o,
  // control and capture
  input wire logic slow_i,
  output logic [543:0] frame_o,
  output int nfr_o
);
  // ==========
  // capture
  logic [543:0] sh;
  logic [6:0] nb;
  logic [1:0] st;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {sh, frame_o, nb, st, ready_o} <= '0;
      nfr_o <= 0;
    end else begin
      st <= st + 2'h1;
      // stalls three cycles of four when slow
      ready_o <= !slow_i || st == 2'h3;
      if (valid_i && ready_o) begin
        sh <= {sh[535:0], data_i};
        nb <= nb == 7'd67 ? 7'd0 : nb + 7'd1;
        if (nb == 7'd67) begin
          frame_o <= {sh[535:0], data_i} & ~{16'hF011, 448'h0};
          nfr_o <= nfr_o + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/tsrf_framer_monitor.sv */
// port assertions for the report framer
`timescale 1ns/1ps
`default_nettype none
module tsrf_framer_monitor #(
  parameter int GAP_CYC = 20
) (
  // clock, reset, triggers
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic OUT_ENABLE_I,
  input wire logic PRIMARY_DONE_I,
  input wire logic POLL_I,
  // status
  input wire tsrf_pkg::tsrf_mode_e MODE_I,
  input wire logic [15:0] SEG_STATUS_I,
  input wire logic SEG_CORRUPT_SET_I,
  input wire logic SEG_QUERY_I,
  input wire tsrf_pkg::tsrf_timing_s TIMING_I,
  // stream
  input wire logic [7:0] TX_DATA_O,
  input wire logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic BUSY_O,
  input wire logic SEG_ALARM_O
);
  // ==========
  // byte position
  // first byte shows a few cycles after the gap runs out
  localparam int GAP_LO = GAP_CYC - 8;
  localparam int GAP_HI = GAP_CYC + 8;
  logic [6:0] c;
  logic v;
  logic rsv;
  assign v = TX_VALID_O;
  assign rsv = c == 2 || (c > 3 && c < 10) || (c > 12 && c < 16)
    || (c > 23 && c < 36) || c > 64;
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      c <= '0;
    end else if (v && TX_READY_I) begin
      c <= c == 7'd67 ? 7'd0 : c + 7'd1;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // ==========
  // checks
  sub_code_a: assert property (
    v && c == 0 |-> TX_DATA_O == 8'hAC) else $error("bad subcode");
  mode_byte_a: assert property (
    v && c == 1 |-> TX_DATA_O == {5'h0, MODE_I}) else $error("bad mode");
  rsv_zero_a: assert property (
    v && rsv |-> TX_DATA_O == 8'h0) else $error("reserved not zero");
  pps_byte_a: assert property (
    v && c == 64 |-> TX_DATA_O == {7'h0, TIMING_I.pps_generated})
    else $error("bad pps byte");
  poll_reply_a: assert property (
    POLL_I && !BUSY_O && !v |-> ##[1:6] v) else $error("no poll reply");
  auto_gap_a: assert property (
    PRIMARY_DONE_I && OUT_ENABLE_I && !BUSY_O && !v && !POLL_I
    |=> (!v)[*8] ##[GAP_LO:GAP_HI] v) else $error("auto timing");
  byte_hold_a: assert property (
    v && !TX_READY_I |=> v && $stable(TX_DATA_O)) else $error("dropped");
  seg_set_a: assert property (
    SEG_CORRUPT_SET_I && (SEG_STATUS_I & 16'h1FFC) != 0 |-> ##2 SEG_ALARM_O)
    else $error("seg alarm not set");
  seg_clear_a: assert property (
    SEG_QUERY_I && !SEG_CORRUPT_SET_I |-> ##2 !SEG_ALARM_O)
    else $error("seg alarm not cleared");
endmodule
bind tsrf_framer tsrf_framer_monitor #(.GAP_CYC(GAP_CYC)) i_mon (.CLK_I,
  .SYS_RST_I, .OUT_ENABLE_I, .PRIMARY_DONE_I, .POLL_I, .MODE_I,
  .SEG_STATUS_I, .SEG_CORRUPT_SET_I, .SEG_QUERY_I, .TIMING_I, .TX_DATA_O,
  .TX_VALID_O, .TX_READY_I, .BUSY_O, .SEG_ALARM_O);
`default_nettype wire

/* File: dv/test_timing_status_report_framer.sv */
// self-checking bench for the report framer
`timescale 1ns/1ps
`default_nettype none
module test_timing_status_report_framer;
  logic clk = 0, rst = 1, en = 0, pd = 0, poll = 0, fv = 0, sa = 0;
  logic sset = 0, sq = 0, slow = 0, rdy, vld, busy, sal;
  logic [7:0] prog = 0, data;
  logic [15:0] sst = 0;
  tsrf_pkg::tsrf_mode_e mode = tsrf_pkg::MODE_AUTO;
  tsrf_pkg::tsrf_alarm_s al = '0;
  tsrf_pkg::tsrf_timing_s tm = '0;
  tsrf_pkg::tsrf_pos_s fix, avg, tpos;
  logic [543:0] frm;
  int nfr, err_count = 0, checks = 0;
  // rows: mode, decode, progress, expected position source
  logic [2:0] md [9] = '{0, 1, 3, 4, 5, 6, 7, 4, 3};
  logic [7:0] dc [9] = '{0, 1, 3, 8, 9, 10, 11, 12, 16};
  logic [7:0] pg [9] = '{40, 0, 0, 100, 0, 0, 0, 99, 100};
  logic [1:0] sl [9] = '{0, 1, 2, 1, 2, 1, 1, 0, 1};
  always #25 clk = ~clk;
  tsrf_framer i_dut (.CLK_I(clk), .SYS_RST_I(rst), .OUT_ENABLE_I(en),
    .PRIMARY_DONE_I(pd), .POLL_I(poll), .MODE_I(mode),
    .SURVEY_PROGRESS_I(prog), .SURVEY_ACTIVE_I(sa), .ALARM_I(al),
    .SEG_STATUS_I(sst), .SEG_CORRUPT_SET_I(sset), .SEG_QUERY_I(sq),
    .TIMING_I(tm), .FIX_VALID_I(fv), .FIX_POS_I(fix), .SURVEY_AVG_I(avg),
    .TIMING_POS_I(tpos), .TX_DATA_O(data), .TX_VALID_O(vld),
    .TX_READY_I(rdy), .BUSY_O(busy), .SEG_ALARM_O(sal));
  tsrf_host i_host (.clk_i(clk), .rst_i(rst), .data_i(data), .valid_i(vld),
    .ready_o(rdy), .slow_i(slow), .frame_o(frm), .nfr_o(nfr));
  // ==========
  // helpers
  task automatic complete_run();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_frame(input string n, input logic [543:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_flag(input string n, input logic e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic wait_frames(input int n);
    for (int k = 0; k < 4000 && nfr < n; k++) @(posedge clk);
    chk_flag("frame count", 1'b1, nfr == n);
  endtask
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: poll <= 1;
      1: pd <= 1;
      2: sset <= 1;
      default: sq <= 1;
    endcase
    @(posedge clk);
    {poll, pd, sset, sq} <= '0;
    // registered status settles one edge after the internal flag
    @(posedge clk);
    @(posedge clk);
  endtask
  task automatic reset_chk();
    repeat (16) @(posedge clk);
    chk_flag("busy", 1'b0, busy);
    chk_flag("valid", 1'b0, vld);
    chk_flag("seg alarm", 1'b0, sal);
    rst <= 0;
  endtask
  function automatic logic [543:0] exp_fr(logic [1:0] s, logic seg);
    logic [191:0] p;
    p = s == 0 ? avg : s == 1 ? tpos : fix;
    return {8'hAC, 5'h0, mode, 8'h0, prog, 48'h0, 4'h0, al.almanac_bad,
      seg, al.pos_suspect, al.test_mode, al.leap_pending, al.no_stored_pos,
      al.survey_active, 1'b0, al.no_usable_sv, al.ant_short, al.ant_open,
      1'b0, tm.decode_status, 24'h0, tm.bias, tm.bias_rate, 96'h0, p,
      tm.qerr, 7'h0, tm.pps_generated, 24'h0};
  endfunction
  // ==========
  // main sequence
  initial begin
    tsrf_pkg::tsrf_alarm_s a;
    for (int k = 0; k < 24; k++) begin
      fix[8*k+:8] = 8'h40 + 8'(k);
      avg[8*k+:8] = 8'h80 + 8'(k);
      tpos[8*k+:8] = 8'hC0 + 8'(k);
    end
    reset_chk();
    en <= 1;
    for (int i = 0; i < 9; i++) begin
      a = (i % 2) ? 9'h1DF : 9'h0AA;
      a.survey_active = pg[i] != 0 && pg[i] < 100;
      mode <= tsrf_pkg::tsrf_mode_e'(md[i]);
      prog <= pg[i];
      sa <= pg[i] != 0;
      al <= a;
      tm <= {dc[i], 32'h3F80_0000 + i, 32'hC120_0000 - i, 32'h4000_0100 | i,
        i[0]};
      slow <= i[1];
      fv <= 1;
      @(posedge clk);
      fv <= 0;
      pulse(i % 2);
      wait_frames(i + 1);
      chk_frame("frame", exp_fr(sl[i], 1'b0), frm);
      // same frame
      // same frame
    end
    sst <= 16'hE003;
    pulse(2);
    chk_flag("seg alarm", 1'b0, sal);
    sst <= 16'h0004;
    pulse(2);
    chk_flag("seg alarm", 1'b1, sal);
    pulse(0);
    wait_frames(10);
    chk_frame("seg frame", exp_fr(sl[8], 1'b1), frm);
    pulse(3);
    chk_flag("seg alarm", 1'b0, sal);
    pulse(0);
    pulse(0);
    pulse(0);
    wait_frames(12);
    repeat (300) @(posedge clk);
    chk_flag("polls merged", 1'b1, nfr == 12);
    en <= 0;
    pulse(1);
    repeat (200) @(posedge clk);
    chk_flag("no auto", 1'b1, nfr == 12);
    pulse(2);
    rst <= 1;
    reset_chk();
    complete_run();
  end
  initial begin
    #(50 * 60000);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
